// *** fan_pwm_map.vh ***
// Register offsets, field positions, reset values and timing constants for the fan block
`ifndef FAN_PWM_MAP_VH
`define FAN_PWM_MAP_VH
// Register offsets
`define OFS_CONFIG_ONE 8'h00
`define OFS_CONFIG_TWO 8'h01
`define OFS_STATUS_ONE 8'h02
`define OFS_STATUS_TWO 8'h03
`define OFS_SPEED_READ 8'h08
`define OFS_TACH_TARGET 8'h10
`define OFS_LOC_HIGH 8'h14
`define OFS_LOC_LOW 8'h15
`define OFS_LOC_OVER 8'h16
`define OFS_REM_HIGH 8'h18
`define OFS_REM_LOW 8'h19
`define OFS_REM_OVER 8'h1A
`define OFS_LOC_SHUT 8'h1B
`define OFS_REM_SHUT 8'h1C
`define OFS_FAN_CHAR 8'h20
`define OFS_DUTY_CFG 8'h22
`define OFS_LOC_RAMP 8'h24
`define OFS_REM_RAMP 8'h25
// Field positions
`define INT_EN_BIT 1
`define MODE_HI 7
`define MODE_LO 5
`define FREQ_HI 5
`define FREQ_LO 3
`define DUTY_HI 3
`define DUTY_LO 0
`define EXT_OVER_BIT 7
`define START_HI 7
`define START_LO 3
`define SPAN_HI 2
`define SPAN_LO 0
// Mode codes
`define MODE_FIXED 3'h0
`define MODE_TARGET 3'h1
`define MODE_AUTO_REM 3'h4
`define MODE_AUTO_BOTH 3'h7
// Reset values
`define RST_CONFIG_ONE 8'h80
`define RST_FAN_CHAR 8'h5D
`define RST_DUTY_CFG 8'h00
`define RST_LOC_RAMP 8'h41
`define RST_REM_RAMP 8'h61
`define RST_TACH_TARGET 8'hFF
`define RST_LOC_HIGH 8'h3C
`define RST_LOC_OVER 8'h46
`define RST_REM_HIGH 8'h50
`define RST_REM_OVER 8'h64
// Duty and speed constants
`define DUTY_FULL 4'hF
`define DUTY_ZERO 4'h0
`define SPEED_STALL 8'hFE
`define SPEED_OVER 8'hFF
`define ZERO_BYTE 8'h00
// Tach reference clock divider (100 MHz / 11.25 kHz)
`define TACH_REF_DIV 8888
// Base PWM slot prescaler at 11.7 Hz with 15 slots (100 MHz / 175.5 Hz)
`define PWM_BASE_DIV 569800
// PWM rates in hundredths of a hertz for the eight frequency codes
`define PWM_RATE_0 1170
`define PWM_RATE_1 1560
`define PWM_RATE_2 2340
`define PWM_RATE_3 3125
`define PWM_RATE_4 3750
`define PWM_RATE_5 4690
`define PWM_RATE_6 6250
`define PWM_RATE_7 9350
`endif

// *** fan_pwm_and_thermal_alarm.v ***
// Thermal alarm comparison, PWM fan drive and fan-speed measurement
`timescale 1ns/1ps
`include "fan_pwm_map.vh"
`default_nettype none
module fan_pwm_and_thermal_alarm #(
  parameter TACH_DIV = `TACH_REF_DIV,
  parameter PWM_DIV = `PWM_BASE_DIV
) (
  // Clock, reset, enable
  input wire i_mclk,
  input wire i_rst,
  input wire i_ce,
  // Register port (decoded bus from the serial slave)
  input wire [7:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  // Converter results
  input wire i_conv_done,
  input wire [7:0] i_local_temp,
  input wire [7:0] i_remote_temp,
  // Limit presets
  input wire i_limit_preset_pin0,
  input wire i_limit_preset_pin1,
  // Tachometer input
  input wire i_tach,
  // Open-drain pins, enable high while pulling low; shutdown outputs driven active high
  input wire i_overtemp_out_n,
  output reg o_overtemp_out_n,
  output reg o_overtemp_oe,
  output reg o_int_n,
  output reg o_int_oe,
  output reg o_local_shutdown_out,
  output reg o_remote_shutdown_out,
  // Fan drive
  output reg o_pwm
);
  // Host-visible registers
  reg [7:0] cfg1_reg;
  reg [7:0] speed_reg;
  reg [7:0] target_reg;
  reg [7:0] fchar_reg;
  reg [7:0] duty_cfg_reg;
  reg [7:0] lim_reg [0:7]; // 0..7: loc hi, loc lo, loc over, rem hi, rem lo, rem over, loc sd, rem sd
  reg [7:0] lramp_reg;
  reg [7:0] rramp_reg;
  reg [7:0] stat1_reg;
  reg ext_over_reg;
  reg [3:0] track_reg; // Duty code used in target mode
  reg preset_done_reg;
  // Overtemp fault latched at conversion end; limit fault vector decoded combinationally
  reg over_fault_reg;
  reg [7:0] limit_fault;
  // PWM timing
  reg [19:0] pre_reg;
  reg [3:0] slot_reg;
  reg [3:0] duty_code;
  reg [19:0] slot_last; // Last prescaler count of one slot
  // Tach measurement
  reg [13:0] ref_div_reg;
  reg [7:0] cnt_reg;
  reg [1:0] edge_cnt_reg;
  reg tach_d_reg;
  reg meas_reg;
  integer k;

  // Fault compare against each limit
  wire loc_hi = $signed(i_local_temp) > $signed(lim_reg[0]);
  wire loc_lo = $signed(i_local_temp) < $signed(lim_reg[1]);
  wire loc_ov = $signed(i_local_temp) > $signed(lim_reg[2]);
  wire rem_hi = $signed(i_remote_temp) > $signed(lim_reg[3]);
  wire rem_lo = $signed(i_remote_temp) < $signed(lim_reg[4]);
  wire rem_ov = $signed(i_remote_temp) > $signed(lim_reg[5]);
  wire loc_sd = $signed(i_local_temp) > $signed(lim_reg[6]);
  wire rem_sd = $signed(i_remote_temp) > $signed(lim_reg[7]);
  wire [2:0] mode = cfg1_reg[`MODE_HI:`MODE_LO];
  // Fan faults: stall always, underspeed suppressed in target mode
  wire stall = (speed_reg == `SPEED_OVER);
  wire under = (mode != `MODE_TARGET) && (speed_reg > target_reg);

  // Automatic ramp duty for one sensor
  function [3:0] ramp_duty;
    input [7:0] temp;
    input [7:0] ramp;
    input [3:0] min_duty;
    reg [7:0] start;
    reg [7:0] over;
    reg [11:0] scaled;
    reg [7:0] span;
    begin
      start = {1'b0, ramp[`START_HI:`START_LO], 2'h0};
      span = 8'h05 << ramp[`SPAN_HI:`SPAN_LO];
      over = temp - start;
      scaled = 12'h000;
      if (temp[7] || (temp <= start))
        ramp_duty = `DUTY_ZERO;
      else if (over >= span)
        ramp_duty = `DUTY_FULL;
      else
      begin
        scaled = {4'h0, over} * 12'h00F / {4'h0, span};
        ramp_duty = (scaled[3:0] < min_duty) ? min_duty : scaled[3:0];
      end
    end
  endfunction

  wire [3:0] rem_duty = ramp_duty(i_remote_temp, rramp_reg, duty_cfg_reg[`DUTY_HI:`DUTY_LO]);
  wire [3:0] loc_duty = ramp_duty(i_local_temp, lramp_reg, duty_cfg_reg[`DUTY_HI:`DUTY_LO]);
  reg [3:0] auto_duty_reg;

  // Active duty selection, external overtemp wins over every mode
  always @*
  begin
    if (ext_over_reg || !i_overtemp_out_n && !o_overtemp_oe)
      duty_code = `DUTY_FULL;
    else
      case (mode)
        `MODE_FIXED: duty_code = duty_cfg_reg[`DUTY_HI:`DUTY_LO];
        `MODE_TARGET: duty_code = track_reg;
        `MODE_AUTO_REM, `MODE_AUTO_BOTH: duty_code = auto_duty_reg;
        default: duty_code = duty_cfg_reg[`DUTY_HI:`DUTY_LO];
      endcase
  end

  // Register writes, preset load and status flags
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cfg1_reg <= `RST_CONFIG_ONE;
      target_reg <= `RST_TACH_TARGET;
      fchar_reg <= `RST_FAN_CHAR;
      duty_cfg_reg <= `RST_DUTY_CFG;
      lramp_reg <= `RST_LOC_RAMP;
      rramp_reg <= `RST_REM_RAMP;
      lim_reg[0] <= `RST_LOC_HIGH;
      lim_reg[1] <= `ZERO_BYTE;
      lim_reg[2] <= `RST_LOC_OVER;
      lim_reg[3] <= `RST_REM_HIGH;
      lim_reg[4] <= `ZERO_BYTE;
      lim_reg[5] <= `RST_REM_OVER;
      lim_reg[6] <= `RST_REM_OVER;
      lim_reg[7] <= `RST_REM_OVER;
      stat1_reg <= `ZERO_BYTE;
      ext_over_reg <= 1'b0;
      preset_done_reg <= 1'b0;
      over_fault_reg <= 1'b0;
      auto_duty_reg <= `DUTY_ZERO;
      o_int_n <= 1'b1;
      o_int_oe <= 1'b0;
      o_overtemp_out_n <= 1'b1;
      o_overtemp_oe <= 1'b0;
      o_local_shutdown_out <= 1'b0;
      o_remote_shutdown_out <= 1'b0;
    end
    else if (i_ce)
    begin
      // Presets caught once after release, limits vary by pin setting
      if (!preset_done_reg)
      begin
        preset_done_reg <= 1'b1;
        for (k = 6; k < 8; k = k + 1)
          lim_reg[k] <= `RST_REM_OVER + {4'h0, i_limit_preset_pin1, i_limit_preset_pin0, 2'h0};
      end
      else if (i_reg_wr)
      begin
        case (i_reg_addr)
          `OFS_CONFIG_ONE: cfg1_reg <= i_reg_wdata;
          `OFS_TACH_TARGET: target_reg <= i_reg_wdata;
          `OFS_FAN_CHAR: fchar_reg <= i_reg_wdata;
          `OFS_DUTY_CFG: duty_cfg_reg <= i_reg_wdata;
          `OFS_LOC_RAMP: lramp_reg <= i_reg_wdata;
          `OFS_REM_RAMP: rramp_reg <= i_reg_wdata;
          `OFS_LOC_HIGH: lim_reg[0] <= i_reg_wdata;
          `OFS_LOC_LOW: lim_reg[1] <= i_reg_wdata;
          `OFS_LOC_OVER: lim_reg[2] <= i_reg_wdata;
          `OFS_REM_HIGH: lim_reg[3] <= i_reg_wdata;
          `OFS_REM_LOW: lim_reg[4] <= i_reg_wdata;
          `OFS_REM_OVER: lim_reg[5] <= i_reg_wdata;
          `OFS_LOC_SHUT: lim_reg[6] <= i_reg_wdata;
          `OFS_REM_SHUT: lim_reg[7] <= i_reg_wdata;
          default: ;
        endcase
      end
      // External pull seen only when this block is not driving; set beats read clear
      if (!i_overtemp_out_n && !o_overtemp_oe)
        ext_over_reg <= 1'b1;
      else if (i_reg_rd && i_reg_addr == `OFS_STATUS_TWO)
        ext_over_reg <= 1'b0;
      // Conversion end: refresh overtemp and shutdown pins and the auto duty
      if (i_conv_done)
      begin
        over_fault_reg <= loc_ov | rem_ov;
        o_overtemp_out_n <= !(loc_ov | rem_ov);
        o_overtemp_oe <= loc_ov | rem_ov;
        o_local_shutdown_out <= loc_sd;
        o_remote_shutdown_out <= rem_sd;
        auto_duty_reg <= (mode == `MODE_AUTO_BOTH && loc_duty > rem_duty) ? loc_duty : rem_duty;
      end
      // Status one: new faults set, read clears, set wins
      if (i_conv_done)
        stat1_reg <= ((i_reg_rd && i_reg_addr == `OFS_STATUS_ONE) ? `ZERO_BYTE : stat1_reg)
          | limit_fault;
      else if (i_reg_rd && i_reg_addr == `OFS_STATUS_ONE)
        stat1_reg <= `ZERO_BYTE;
      // Interrupt pin follows status and enable bit
      o_int_n <= !((stat1_reg != `ZERO_BYTE) && cfg1_reg[`INT_EN_BIT]);
      o_int_oe <= (stat1_reg != `ZERO_BYTE) && cfg1_reg[`INT_EN_BIT];
    end
  end

  // Status one layout: limit bits and one fan fault bit for stall or underspeed
  always @*
  begin
    limit_fault = {stall | under, rem_hi, rem_lo, loc_hi, loc_lo, rem_ov, loc_ov, 1'b0};
  end

  // Slot length per rate code, scaled from the slowest rate; integer division rounds down
  localparam [31:0] SLOT_F0 = PWM_DIV;
  localparam [31:0] SLOT_F1 = PWM_DIV * `PWM_RATE_0 / `PWM_RATE_1;
  localparam [31:0] SLOT_F2 = PWM_DIV * `PWM_RATE_0 / `PWM_RATE_2;
  localparam [31:0] SLOT_F3 = PWM_DIV * `PWM_RATE_0 / `PWM_RATE_3;
  localparam [31:0] SLOT_F4 = PWM_DIV * `PWM_RATE_0 / `PWM_RATE_4;
  localparam [31:0] SLOT_F5 = PWM_DIV * `PWM_RATE_0 / `PWM_RATE_5;
  localparam [31:0] SLOT_F6 = PWM_DIV * `PWM_RATE_0 / `PWM_RATE_6;
  localparam [31:0] SLOT_F7 = PWM_DIV * `PWM_RATE_0 / `PWM_RATE_7;
  // Rate table lookup; rates are not powers of two, so no plain shift
  always @*
  begin
    case (fchar_reg[`FREQ_HI:`FREQ_LO])
      3'h0: slot_last = SLOT_F0[19:0] - 20'h00001;
      3'h1: slot_last = SLOT_F1[19:0] - 20'h00001;
      3'h2: slot_last = SLOT_F2[19:0] - 20'h00001;
      3'h3: slot_last = SLOT_F3[19:0] - 20'h00001;
      3'h4: slot_last = SLOT_F4[19:0] - 20'h00001;
      3'h5: slot_last = SLOT_F5[19:0] - 20'h00001;
      3'h6: slot_last = SLOT_F6[19:0] - 20'h00001;
      default: slot_last = SLOT_F7[19:0] - 20'h00001;
    endcase
  end

  // Prescaled slot counter and comparator form the PWM
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      pre_reg <= 20'h00000;
      slot_reg <= 4'h0;
      o_pwm <= 1'b0;
    end
    else if (i_ce)
    begin
      // Higher frequency codes shorten the slot time
      if (pre_reg >= slot_last)
      begin
        pre_reg <= 20'h00000;
        slot_reg <= (slot_reg == 4'hE) ? 4'h0 : slot_reg + 4'h1; // 15 slots give fifteenths
      end
      else
        pre_reg <= pre_reg + 20'h00001;
      o_pwm <= (slot_reg < duty_code);
    end
  end

  // First clock of a PWM period, present even at 0 or 100 percent drive
  wire period_start = (slot_reg == 4'h0) && (pre_reg == 20'h00000);

  // Tach period counter, reference-clock gated over two tach periods
  always @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ref_div_reg <= 14'h0000;
      cnt_reg <= `ZERO_BYTE;
      edge_cnt_reg <= 2'h0;
      tach_d_reg <= 1'b0;
      meas_reg <= 1'b0;
      speed_reg <= `SPEED_OVER;
      track_reg <= `DUTY_FULL;
    end
    else if (i_ce)
    begin
      tach_d_reg <= i_tach;
      // One reference tick every TACH_DIV clocks
      ref_div_reg <= (ref_div_reg >= TACH_DIV[13:0] - 14'h0001) ? 14'h0000 :
        ref_div_reg + 14'h0001;
      // Start at a PWM period start when idle; a steady drive has no edge to start on
      if (!meas_reg && period_start)
      begin
        meas_reg <= 1'b1;
        edge_cnt_reg <= 2'h0;
        cnt_reg <= `ZERO_BYTE;
      end
      else if (meas_reg)
      begin
        if (i_tach && !tach_d_reg)
          edge_cnt_reg <= edge_cnt_reg + 2'h1;
        // Count between first and third seen edges, saturating
        if (edge_cnt_reg != 2'h0 && ref_div_reg == 14'h0000 && cnt_reg != `SPEED_OVER)
          cnt_reg <= cnt_reg + 8'h01;
        if ((edge_cnt_reg == 2'h3) || (cnt_reg == `SPEED_OVER))
        begin
          meas_reg <= 1'b0;
          speed_reg <= cnt_reg;
          // Larger count means slower fan
          if (mode == `MODE_TARGET && cnt_reg > target_reg && track_reg != `DUTY_FULL)
            track_reg <= track_reg + 4'h1;
          else if (mode == `MODE_TARGET && cnt_reg < target_reg && track_reg != `DUTY_ZERO)
            track_reg <= track_reg - 4'h1;
        end
      end
    end
  end

  // Registered read data, unmapped offsets read zero
  always @(posedge i_mclk)
  begin
    if (i_rst)
      o_reg_rdata <= `ZERO_BYTE;
    else if (i_ce)
      case (i_reg_addr)
        `OFS_CONFIG_ONE: o_reg_rdata <= cfg1_reg;
        `OFS_STATUS_ONE: o_reg_rdata <= stat1_reg;
        `OFS_STATUS_TWO: o_reg_rdata <= {ext_over_reg, 6'h00, over_fault_reg};
        `OFS_SPEED_READ: o_reg_rdata <= speed_reg;
        `OFS_TACH_TARGET: o_reg_rdata <= target_reg;
        `OFS_FAN_CHAR: o_reg_rdata <= fchar_reg;
        `OFS_DUTY_CFG: o_reg_rdata <= duty_cfg_reg;
        `OFS_LOC_RAMP: o_reg_rdata <= lramp_reg;
        `OFS_REM_RAMP: o_reg_rdata <= rramp_reg;
        `OFS_LOC_HIGH: o_reg_rdata <= lim_reg[0];
        `OFS_LOC_LOW: o_reg_rdata <= lim_reg[1];
        `OFS_LOC_OVER: o_reg_rdata <= lim_reg[2];
        `OFS_REM_HIGH: o_reg_rdata <= lim_reg[3];
        `OFS_REM_LOW: o_reg_rdata <= lim_reg[4];
        `OFS_REM_OVER: o_reg_rdata <= lim_reg[5];
        `OFS_LOC_SHUT: o_reg_rdata <= lim_reg[6];
        `OFS_REM_SHUT: o_reg_rdata <= lim_reg[7];
        default: o_reg_rdata <= `ZERO_BYTE;
      endcase
  end
endmodule // fan_pwm_and_thermal_alarm
`default_nettype wire

// *** fan_pwm_checker.sv ***
// Port-level assertions for the fan drive and thermal alarm block
`timescale 1ns/1ps
`default_nettype none
module fan_pwm_checker (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_conv_done,
  input wire logic i_overtemp_out_n,
  input wire logic o_overtemp_oe,
  input wire logic o_int_oe,
  input wire logic o_local_shutdown_out,
  input wire logic o_remote_shutdown_out,
  input wire logic o_pwm
);
  logic int_en_reg; // Shadow of the interrupt enable bit
  // Follow host writes so the enable is known without peeking inside
  always @(posedge i_mclk)
  begin
    if (i_rst)
      int_en_reg <= 1'b0;
    else if (i_ce && i_reg_wr && i_reg_addr == 8'h00)
      int_en_reg <= i_reg_wdata[1];
  end
  default clocking cb @(posedge i_mclk); endclocking
  property p_rd_rst; i_rst |=> o_reg_rdata == 8'h00; endproperty
  a_rd_rst: assert property (p_rd_rst) else $error("rdata not cleared");
  property p_pin_rst; i_rst |=> !o_int_oe && !o_overtemp_oe && !o_pwm; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pins not idle");
  property p_sd_rst; i_rst |=> !o_local_shutdown_out && !o_remote_shutdown_out; endproperty
  a_sd_rst: assert property (p_sd_rst) else $error("shutdown not idle");
  property p_unmap; disable iff (i_rst) i_ce && i_reg_addr == 8'h30 |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // Pins may only move after a conversion result arrives
  property p_sd_hold; disable iff (i_rst) !i_conv_done && !$past(i_conv_done) |=>
    $stable(o_local_shutdown_out) && $stable(o_remote_shutdown_out); endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("shutdown moved");
  property p_ovt_hold; disable iff (i_rst) !i_conv_done && !$past(i_conv_done) |=>
    $stable(o_overtemp_oe); endproperty
  a_ovt_hold: assert property (p_ovt_hold) else $error("overtemp moved");
  property p_int_off; disable iff (i_rst) !int_en_reg && !$past(int_en_reg) |-> !o_int_oe;
  endproperty
  a_int_off: assert property (p_int_off) else $error("int while off");
  property p_int_rel; disable iff (i_rst) i_ce && i_reg_rd && i_reg_addr == 8'h02 &&
    !i_conv_done ##1 !i_conv_done |=> !o_int_oe; endproperty
  a_int_rel: assert property (p_int_rel) else $error("int not released");
  property p_ext; disable iff (i_rst) (!i_overtemp_out_n && !o_overtemp_oe) [*2] |-> o_pwm;
  endproperty
  a_ext: assert property (p_ext) else $error("no full drive");
  c_int: cover property (disable iff (i_rst) $rose(o_int_oe));
  c_ext: cover property (disable iff (i_rst) !i_overtemp_out_n && !o_overtemp_oe);
  c_sd: cover property (disable iff (i_rst) $rose(o_local_shutdown_out));
endmodule // fan_pwm_checker
`default_nettype wire

// *** fan_tach_model.sv ***
// Behavioural DC fan with a pulled-up tachometer output
`timescale 1ns/1ps
`default_nettype none
module fan_tach_model (
  input wire logic i_mclk,
  input wire logic [15:0] i_half,
  output logic o_tach
);
  logic [15:0] cnt_reg = 16'h0000; // Clocks into this half period
  initial o_tach = 1'b1;
  // Toggle each half period; a stopped fan rests at the pull-up level
  always @(posedge i_mclk)
  begin
    cnt_reg <= cnt_reg + 16'h0001;
    if (i_half == 16'h0000)
      o_tach <= 1'b1;
    else if (cnt_reg >= i_half - 16'h0001)
    begin
      cnt_reg <= 16'h0000;
      o_tach <= ~o_tach;
    end
  end
endmodule // fan_tach_model
`default_nettype wire

// *** tb_fan_pwm_and_thermal_alarm.sv ***
// Self-checking bench for the fan drive and thermal alarm block
`timescale 1ns/1ps
`default_nettype none
`include "fan_pwm_map.vh"
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
$display("Error %s exp %h got %h", n, e, a); end end
module tb_fan_pwm_and_thermal_alarm;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_conv_done = 1'b0;
  logic ext_pull = 1'b0; // Outside party pulling the overtemp wire
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, i_local_temp = 8'h00;
  logic [7:0] i_remote_temp = 8'h00, d;
  logic [15:0] half = 16'h0064; // Fan half period in clocks
  logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
  int num_errors = 0, total_checks = 0, hi, lo;
  wire [7:0] o_reg_rdata;
  wire i_tach, o_pwm, o_int_n, o_int_oe, o_overtemp_out_n, o_overtemp_oe;
  wire o_local_shutdown_out, o_remote_shutdown_out;
  wire i_overtemp_out_n = ~(o_overtemp_oe | ext_pull); // Pulled-up shared wire
  always #5 i_mclk = ~i_mclk;
  fan_pwm_and_thermal_alarm #(.TACH_DIV(4), .PWM_DIV(8)) fan_pwm_and_thermal_alarm_inst (
    .i_mclk, .i_rst, .i_ce(1'b1), .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
    .o_reg_rdata, .i_conv_done, .i_local_temp, .i_remote_temp, .i_limit_preset_pin0(1'b0),
    .i_limit_preset_pin1(1'b1), .i_tach, .i_overtemp_out_n, .o_overtemp_out_n,
    .o_overtemp_oe, .o_int_n, .o_int_oe, .o_local_shutdown_out, .o_remote_shutdown_out,
    .o_pwm);
  fan_tach_model fan_tach_model_inst (.i_mclk, .i_half(half), .o_tach(i_tach));
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    #1 i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    @(posedge i_mclk);
    #1 i_reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_mclk);
    #1 i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(posedge i_mclk);
    #1 i_reg_rd = 1'b0;
    d = o_reg_rdata;
  endtask
  task conv(input logic [7:0] l, input logic [7:0] r);
    @(posedge i_mclk);
    #1 i_local_temp = l;
    i_remote_temp = r;
    i_conv_done = 1'b1;
    @(posedge i_mclk);
    #1 i_conv_done = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
  endtask
  // High and low time of one full period; bounded for a steady level
  task meas;
    hi = 0;
    lo = 0;
    for (int n = 0; n < 1500 && !(lo && o_pwm); n++)
      @(posedge i_mclk) #1 lo = lo | !o_pwm;
    lo = 0;
    for (int n = 0; n < 1500 && o_pwm; n++)
      @(posedge i_mclk) #1 hi++;
    for (int n = 0; n < 1500 && !o_pwm; n++)
      @(posedge i_mclk) #1 lo++;
  endtask
  task t_regs;
    rd(`OFS_CONFIG_ONE);
    `CHK("mode", 3'h4, d[7:5])
    rd(`OFS_FAN_CHAR);
    `CHK("freq", 3'h3, d[5:3])
    rd(8'h30);
    `CHK("unmapped", 8'h00, d)
  endtask
  task t_duty;
    wr(`OFS_CONFIG_ONE, 8'h00);
    foreach (codes[i])
    begin
      wr(`OFS_DUTY_CFG, {4'h0, codes[i]});
      repeat (300) @(posedge i_mclk);
      meas();
      `CHK("duty", (hi + lo) * codes[i], hi * 15)
    end
    // 15 slots of PWM_DIV clocks at 11.7 Hz; 15.6 Hz runs four thirds as fast
    wr(`OFS_DUTY_CFG, 8'h08);
    wr(`OFS_FAN_CHAR, 8'h40);
    repeat (300) @(posedge i_mclk);
    meas();
    `CHK("period_slow", 15 * 8, hi + lo)
    wr(`OFS_FAN_CHAR, 8'h48);
    repeat (300) @(posedge i_mclk);
    meas();
    `CHK("period_next", 15 * 8 * 3 / 4, hi + lo)
    wr(`OFS_FAN_CHAR, `RST_FAN_CHAR);
  endtask
  task t_alarm;
    wr(`OFS_CONFIG_ONE, 8'h02);
    conv(8'h47, 8'h10);
    `CHK("ovt", 1'b1, o_overtemp_oe)
    `CHK("ovt_pin", 1'b0, o_overtemp_out_n)
    `CHK("int", 1'b1, o_int_oe)
    `CHK("int_pin", 1'b0, o_int_n)
    rd(`OFS_STATUS_ONE);
    `CHK("status1", 8'h12, d)
    @(posedge i_mclk);
    #1;
    `CHK("int_rel", 1'b0, o_int_oe)
    conv(8'h47, 8'h10);
    `CHK("int_again", 1'b1, o_int_oe)
    wr(`OFS_CONFIG_ONE, 8'h00);
    repeat (2) @(posedge i_mclk);
    #1;
    `CHK("int_off", 1'b0, o_int_oe)
  endtask
  task t_shut;
    conv(8'h6D, 8'h6C);
    `CHK("sd_loc", 1'b1, o_local_shutdown_out)
    `CHK("sd_rem", 1'b0, o_remote_shutdown_out)
    rd(`OFS_LOC_SHUT);
    `CHK("preset", 8'h6C, d)
    wr(`OFS_REM_SHUT, 8'h6B);
    conv(8'h10, 8'h6C);
    `CHK("sd_loc2", 1'b0, o_local_shutdown_out)
    `CHK("sd_rem2", 1'b1, o_remote_shutdown_out)
  endtask
  task t_ext;
    conv(8'h10, 8'h10);
    `CHK("ovt_clr", 1'b0, o_overtemp_oe)
    wr(`OFS_DUTY_CFG, 8'h00);
    ext_pull = 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    `CHK("full", 1'b1, o_pwm)
    ext_pull = 1'b0;
    repeat (20) @(posedge i_mclk);
    rd(`OFS_STATUS_TWO);
    `CHK("ext_flag", 1'b1, d[7])
    rd(`OFS_STATUS_TWO);
    `CHK("ext_clr", 1'b0, d[7])
  endtask
  task t_speed;
    wr(`OFS_DUTY_CFG, 8'h08);
    repeat (2000) @(posedge i_mclk);
    rd(`OFS_SPEED_READ);
    `CHK("speed", 1'b1, d + 8'h01 >= half[7:0] && d <= half[7:0] + 8'h01)
    half = 16'h0258;
    repeat (6000) @(posedge i_mclk);
    rd(`OFS_SPEED_READ);
    `CHK("overrange", 8'hFF, d)
    conv(8'h10, 8'h10); // Status only refreshes at conversion end
    rd(`OFS_STATUS_ONE);
    `CHK("stall", 1'b1, d[7])
    half = 16'h0064;
  endtask
  // Fan count stays near 100: a target above it walks the duty to zero, below it to full
  task t_target;
    wr(`OFS_CONFIG_ONE, 8'h20);
    wr(`OFS_TACH_TARGET, 8'hC8);
    repeat (11000) @(posedge i_mclk);
    meas();
    `CHK("slow_down", 32'h0, hi)
    wr(`OFS_TACH_TARGET, 8'h10);
    repeat (11000) @(posedge i_mclk);
    conv(8'h10, 8'h10);
    rd(`OFS_STATUS_ONE);
    `CHK("no_under", 1'b0, d[7])
    meas();
    `CHK("ramp", 32'h0, lo)
  endtask
  // Remote ramp starts above 48 C over 10 C, local above 32 C over 10 C
  task t_auto;
    wr(`OFS_DUTY_CFG, 8'h02);
    wr(`OFS_CONFIG_ONE, 8'h80);
    conv(8'h10, 8'h3F);
    meas();
    `CHK("auto_full", 32'h0, lo)
    conv(8'h10, 8'h31);
    meas();
    `CHK("auto_min", (hi + lo) * 2, hi * 15)
    conv(8'h2A, 8'h10);
    meas();
    `CHK("auto_off", 32'h0, hi)
    wr(`OFS_CONFIG_ONE, 8'hE0);
    conv(8'h2A, 8'h10);
    meas();
    `CHK("auto_both", 32'h0, lo)
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole run is near 54000 clocks; the limit leaves margin
  initial
  begin
    #1000000;
    num_errors++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    repeat (2) @(posedge i_mclk);
    t_regs();
    t_duty();
    t_alarm();
    t_shut();
    t_ext();
    t_speed();
    t_target();
    t_auto();
    complete_run();
  end
endmodule // tb_fan_pwm_and_thermal_alarm
bind fan_pwm_and_thermal_alarm fan_pwm_checker fan_pwm_checker_inst (.i_mclk, .i_rst, .i_ce,
  .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata, .i_conv_done,
  .i_overtemp_out_n, .o_overtemp_oe, .o_int_oe, .o_local_shutdown_out,
  .o_remote_shutdown_out, .o_pwm);
`default_nettype wire
